// file: hdl/irqg_pkg.sv
package irqg_pkg;

	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned G3_SRC_W = 4;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_G2_HI = 12'hFC7;
	localparam logic [ADDR_W-1:0] OFS_G2_LO = 12'hFC8;
	localparam logic [ADDR_W-1:0] OFS_G3_HI = 12'hFCA;
	localparam logic [ADDR_W-1:0] OFS_G3_LO = 12'hFCB;
	localparam logic [ADDR_W-1:0] OFS_EDGE = 12'hFCC;
	localparam logic [ADDR_W-1:0] OFS_SHARED = 12'hFCD;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 12'hFCF;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 12'hFD0;
	localparam logic [ADDR_W-1:0] OFS_MASK = 12'hFD1;

	// ------------------------------------------------------------
	// Field layouts and reset values
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0] RST_VAL = 8'h00;
	localparam logic [DATA_W-1:0] G3_WR_MASK = 8'hCF;
	localparam int unsigned CTRL_GIE_BIT = 7;
	localparam int unsigned SEL_LVD_BIT = 7;
	localparam int unsigned SEL_CMP0_BIT = 6;
	localparam int unsigned SEL_CMP1_BIT = 5;
	localparam int unsigned SEL_PD_HI = 4;
	localparam int unsigned SEL_PD_LO = 1;
	localparam int unsigned G3_TIMER_A_BIT = 7;
	localparam int unsigned G3_MCT_BIT = 6;

	// ------------------------------------------------------------
	// Priority codes, {high bit, low bit}
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		LVL_OFF = 2'h0,
		LVL_LOW = 2'h1,
		LVL_NOMINAL = 2'h2,
		LVL_HIGH = 2'h3
	} irqg_level_type;

endpackage

// file: hdl/irqg_top.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// R1: Enable pair {high,low} per source: 00 off, 01 low, 10 nominal, 11 high.
// R2: Group 2 bit 7 pin A7/low volt, bit 6 A6/cmp0, bit 5 A5/cmp1.
// R3: Group 2 bits 4..1 pin A or D of same index, bit 0 pin A0.
// R4: Pin A or alternate choice comes from shared select, not enable bits.
// R5: Group 3 bit 7 timer A, 6 multichannel timer, 3..0 port C; 5:4 read-only.
// R6: Software writes zeros to group 3 reserved bits 5 and 4.
// R7: Edge bit 0 falling edge raises request, 1 rising edge.
// R8: Edge bit applies only to the currently selected line of that index.
// R9: Shared select 0 takes pin A line, 1 takes alternate line.
// R10: Global enable 0 blocks requests; 1 passes them at programmed priority. Only cpu_req_o and cpu_level_o are gated; irq_o ignores it.
// R11: Reset clears enables and edge bits: all off, falling edges.
module irqg_top
(
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [11:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] pin_a_i,
	input wire logic [7:0] pin_d_i,
	input wire logic low_voltage_detect_i,
	input wire logic cmp0_i,
	input wire logic cmp1_i,
	input wire logic timer_a_req_i,
	input wire logic multichannel_timer_req_i,
	input wire logic [3:0] portc_req_i,
	output logic [7:0] rdata_o,
	output logic [7:0] edge_req_o,
	output logic cpu_req_o,
	output logic [1:0] cpu_level_o,
	output logic irq_o
);

	logic [7:0] group2_enable_high;
	logic [7:0] group2_enable_low;
	logic [7:0] group3_enable_high;
	logic [7:0] group3_enable_low;
	logic [7:0] edge_polarity_select;
	logic [7:0] shared_source_select;
	logic global_irq_enable;
	logic [7:0] status;
	logic [7:0] mask;
	logic [7:0] sel_line;
	logic [7:0] prev_line;
	logic primed;
	logic [7:0] edge_hit;
	logic [7:0] g3_req;
	logic [1:0] next_level;
	logic [7:0] next_rdata;
	logic wr_g2h;
	logic wr_g2l;
	logic wr_g3h;
	logic wr_g3l;
	logic wr_edge;
	logic wr_shared;
	logic wr_ctrl;
	logic wr_status;
	logic wr_mask;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	assign wr_g2h = wr_i && (addr_i == irqg_pkg::OFS_G2_HI);
	assign wr_g2l = wr_i && (addr_i == irqg_pkg::OFS_G2_LO);
	assign wr_g3h = wr_i && (addr_i == irqg_pkg::OFS_G3_HI);
	assign wr_g3l = wr_i && (addr_i == irqg_pkg::OFS_G3_LO);
	assign wr_edge = wr_i && (addr_i == irqg_pkg::OFS_EDGE);
	assign wr_shared = wr_i && (addr_i == irqg_pkg::OFS_SHARED);
	assign wr_ctrl = wr_i && (addr_i == irqg_pkg::OFS_CTRL);
	assign wr_status = wr_i && (addr_i == irqg_pkg::OFS_STATUS);
	assign wr_mask = wr_i && (addr_i == irqg_pkg::OFS_MASK);

	// ------------------------------------------------------------
	// Enable and priority registers
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			group2_enable_high <= irqg_pkg::RST_VAL; // [R11]
			group2_enable_low <= irqg_pkg::RST_VAL; // [R11]
			group3_enable_high <= irqg_pkg::RST_VAL; // [R11]
			group3_enable_low <= irqg_pkg::RST_VAL; // [R11]
		end
		else
		begin
			if (wr_g2h)
			begin
				group2_enable_high <= wdata_i;
			end
			if (wr_g2l)
			begin
				group2_enable_low <= wdata_i;
			end
			if (wr_g3h)
			begin
				group3_enable_high <= wdata_i & irqg_pkg::G3_WR_MASK; // [R5]
			end
			if (wr_g3l)
			begin
				group3_enable_low <= wdata_i & irqg_pkg::G3_WR_MASK; // [R5]
			end
		end
	end

	// ------------------------------------------------------------
	// Edge select, shared select and global enable
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			edge_polarity_select <= irqg_pkg::RST_VAL; // [R11]
			shared_source_select <= irqg_pkg::RST_VAL;
			global_irq_enable <= 1'b0;
		end
		else
		begin
			if (wr_edge)
			begin
				edge_polarity_select <= wdata_i;
			end
			if (wr_shared)
			begin
				shared_source_select <= wdata_i;
			end
			if (wr_ctrl)
			begin
				global_irq_enable <= wdata_i[irqg_pkg::CTRL_GIE_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// Source selection and edge detection
	// ------------------------------------------------------------
	always_comb
	begin
		sel_line = pin_a_i; // [R9]
		if (shared_source_select[irqg_pkg::SEL_LVD_BIT])
		begin
			sel_line[irqg_pkg::SEL_LVD_BIT] = low_voltage_detect_i; // [R2]
		end
		if (shared_source_select[irqg_pkg::SEL_CMP0_BIT])
		begin
			sel_line[irqg_pkg::SEL_CMP0_BIT] = cmp0_i; // [R2]
		end
		if (shared_source_select[irqg_pkg::SEL_CMP1_BIT])
		begin
			sel_line[irqg_pkg::SEL_CMP1_BIT] = cmp1_i; // [R2]
		end
		for (int k = irqg_pkg::SEL_PD_LO; k <= irqg_pkg::SEL_PD_HI; k++)
		begin
			if (shared_source_select[k])
			begin
				sel_line[k] = pin_d_i[k]; // [R3] [R4]
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			prev_line <= irqg_pkg::RST_VAL;
			primed <= 1'b0;
		end
		else
		begin
			prev_line <= sel_line;
			primed <= 1'b1;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_edge
			// Polarity acts on whichever line is selected now
			assign edge_hit[gi] = primed && (edge_polarity_select[gi] ?
				(sel_line[gi] && !prev_line[gi]) :
				(!sel_line[gi] && prev_line[gi])); // [R7] [R8]
		end
	endgenerate

	// ------------------------------------------------------------
	// Event status, mask and interrupt line
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			status <= irqg_pkg::RST_VAL;
			mask <= irqg_pkg::RST_VAL;
			edge_req_o <= irqg_pkg::RST_VAL;
			irq_o <= 1'b0;
		end
		else
		begin
			// A new edge wins over a write-one clear in the same cycle
			status <= (status & ~(wr_status ? wdata_i : 8'h00)) | edge_hit;
			if (wr_mask)
			begin
				mask <= wdata_i;
			end
			edge_req_o <= edge_hit;
			irq_o <= |(status & mask);
		end
	end

	// ------------------------------------------------------------
	// Priority resolution toward the processor
	// ------------------------------------------------------------
	assign g3_req = {timer_a_req_i, multichannel_timer_req_i, 2'h0, portc_req_i}; // [R5]

	always_comb
	begin
		next_level = irqg_pkg::LVL_OFF;
		for (int k = 0; k < 8; k++)
		begin
			if (status[k] && {group2_enable_high[k], group2_enable_low[k]} > next_level)
			begin
				next_level = {group2_enable_high[k], group2_enable_low[k]}; // [R1]
			end
			if (g3_req[k] && {group3_enable_high[k], group3_enable_low[k]} > next_level)
			begin
				next_level = {group3_enable_high[k], group3_enable_low[k]}; // [R1]
			end
		end
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cpu_req_o <= 1'b0;
			cpu_level_o <= irqg_pkg::LVL_OFF;
		end
		else
		begin
			cpu_req_o <= global_irq_enable && (next_level != irqg_pkg::LVL_OFF); // [R10]
			cpu_level_o <= global_irq_enable ? next_level : irqg_pkg::LVL_OFF; // [R10]
		end
	end

	// ------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------
	always_comb
	begin
		unique case (addr_i)
			irqg_pkg::OFS_G2_HI: next_rdata = group2_enable_high;
			irqg_pkg::OFS_G2_LO: next_rdata = group2_enable_low;
			irqg_pkg::OFS_G3_HI: next_rdata = group3_enable_high;
			irqg_pkg::OFS_G3_LO: next_rdata = group3_enable_low;
			irqg_pkg::OFS_EDGE: next_rdata = edge_polarity_select;
			irqg_pkg::OFS_SHARED: next_rdata = shared_source_select;
			irqg_pkg::OFS_CTRL: next_rdata = {global_irq_enable, 7'h00};
			irqg_pkg::OFS_STATUS: next_rdata = status;
			irqg_pkg::OFS_MASK: next_rdata = mask;
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rdata_o <= irqg_pkg::RST_VAL;
		end
		else
		begin
			rdata_o <= rd_i ? next_rdata : 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	prio_code_a: assert property (cpu_req_o |-> cpu_level_o != irqg_pkg::LVL_OFF) // [R1]
		else $error("request raised with level off");

	lvd_map_a: assert property ( // [R2]
		primed && shared_source_select[7] && $stable(shared_source_select)
		&& edge_polarity_select[7] && $rose(low_voltage_detect_i) |=> edge_req_o[7])
		else $error("low voltage edge missed");

	pin_map_a: assert property ( // [R3]
		primed && !shared_source_select[2] && $stable(shared_source_select)
		&& !edge_polarity_select[2] && $fell(pin_a_i[2]) |=> edge_req_o[2])
		else $error("pin A2 falling edge missed");

	alt_sel_a: assert property ( // [R4]
		primed && shared_source_select[3] && $stable(shared_source_select)
		&& $stable(pin_d_i[3]) |=> !edge_req_o[3])
		else $error("port A line seen while D selected");

	g3_resv_a: assert property ( // [R5]
		group3_enable_high[5:4] == 2'h0
		&& group3_enable_low[5:4] == 2'h0)
		else $error("group 3 reserved bits set");

	edge_pol_a: assert property ( // [R7]
		primed && !edge_polarity_select[0] && $stable(edge_polarity_select)
		&& !shared_source_select[0] && $rose(pin_a_i[0]) |=> !edge_req_o[0])
		else $error("rising edge taken under falling select");

	alt_rise_a: assert property ( // [R8] [R9]
		primed && shared_source_select[1] && $stable(shared_source_select)
		&& edge_polarity_select[1] && $rose(pin_d_i[1]) |=> edge_req_o[1])
		else $error("port D rising edge missed");

	gie_gate_a: assert property (!global_irq_enable |=> !cpu_req_o) // [R10]
		else $error("request passed with global enable off");

	gie_level_a: assert property (!global_irq_enable |=> cpu_level_o == irqg_pkg::LVL_OFF) // [R10]
		else $error("level shown with global enable off");

	reset_clr_a: assert property ( // [R11]
		$fell(rst_i) |-> group2_enable_high == 8'h00
		&& group2_enable_low == 8'h00 && edge_polarity_select == 8'h00)
		else $error("registers not cleared by reset");

	irq_line_a: assert property (|(status & mask) |=> irq_o)
		else $error("interrupt line not raised");

	status_set_a: assert property (edge_hit != 8'h00
		|=> (status & $past(edge_hit)) == $past(edge_hit))
		else $error("edge not held in status");

	status_clr_a: assert property (wr_status && wdata_i[0] && !edge_hit[0]
		|=> !status[0])
		else $error("status bit not cleared by write");

	edge_cov_c: cover property (edge_req_o != 8'h00);
	high_lvl_c: cover property (cpu_req_o && cpu_level_o == irqg_pkg::LVL_HIGH);
	irq_cov_c: cover property (irq_o ##1 !irq_o);
	alt_edge_c: cover property (shared_source_select[7] && edge_req_o[7]);

endmodule // irqg_top
`default_nettype wire

// file: bench/irqg_top_test.sv
`timescale 1ns/100ps
`default_nettype none
module irqg_top_test;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic [11:0] addr_i = 12'h000;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] pin_a_i = 8'hFF;
	logic [7:0] pin_d_i = 8'hFF;
	logic low_voltage_detect_i = 1'b1;
	logic cmp0_i = 1'b1;
	logic cmp1_i = 1'b1;
	logic timer_a_req_i = 1'b0;
	logic multichannel_timer_req_i = 1'b0;
	logic [3:0] portc_req_i = 4'h0;
	logic [7:0] rdata_o;
	logic [7:0] edge_req_o;
	logic cpu_req_o;
	logic [1:0] cpu_level_o;
	logic irq_o;
	int bad_count = 0;
	int comparisons = 0;
	logic [7:0] seen;

	always #10 clock_i = ~clock_i;

	irqg_top irqg_top_i
	(
		.clock_i(clock_i),
		.rst_i(rst_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.pin_a_i(pin_a_i),
		.pin_d_i(pin_d_i),
		.low_voltage_detect_i(low_voltage_detect_i),
		.cmp0_i(cmp0_i),
		.cmp1_i(cmp1_i),
		.timer_a_req_i(timer_a_req_i),
		.multichannel_timer_req_i(multichannel_timer_req_i),
		.portc_req_i(portc_req_i),
		.rdata_o(rdata_o),
		.edge_req_o(edge_req_o),
		.cpu_req_o(cpu_req_o),
		.cpu_level_o(cpu_level_o),
		.irq_o(irq_o)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input string what);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1;
		check(what, rdata_o, exp);
	endtask

	task automatic settle;
		repeat (3) @(posedge clock_i);
		#1;
	endtask

	// Drives the lines, then gathers every edge pulse over three cycles
	task automatic edge_try(input logic [7:0] a, input logic [7:0] d, input logic [2:0] alt,
		input logic [7:0] exp);
		@(posedge clock_i);
		pin_a_i <= a;
		pin_d_i <= d;
		{low_voltage_detect_i, cmp0_i, cmp1_i} <= alt;
		seen = 8'h00;
		repeat (3)
		begin
			@(posedge clock_i);
			#1;
			seen = seen | edge_req_o;
		end
		check("edge_req", seen, exp);
	endtask

	task automatic cpu_chk(input logic req, input logic [1:0] lvl);
		settle;
		check("cpu_req", {7'h00, cpu_req_o}, {7'h00, req});
		check("cpu_level", {6'h00, cpu_level_o}, {6'h00, lvl});
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		rd_chk(irqg_pkg::OFS_G2_HI, 8'h00, "g2_hi");
		rd_chk(irqg_pkg::OFS_G2_LO, 8'h00, "g2_lo");
		rd_chk(irqg_pkg::OFS_G3_HI, 8'h00, "g3_hi");
		rd_chk(irqg_pkg::OFS_G3_LO, 8'h00, "g3_lo");
		rd_chk(irqg_pkg::OFS_EDGE, 8'h00, "edge");
		rd_chk(12'h100, 8'h00, "unmapped");
		$display("reset values done");
	endtask

	task automatic t_edge;
		edge_try(8'hFE, 8'hFF, 3'h7, 8'h01);
		edge_try(8'hFF, 8'hFF, 3'h7, 8'h00);
		wr(irqg_pkg::OFS_EDGE, 8'h01);
		edge_try(8'hFE, 8'hFF, 3'h7, 8'h00);
		edge_try(8'hFF, 8'hFF, 3'h7, 8'h01);
		$display("edge polarity done");
	endtask

	task automatic t_shared;
		wr(irqg_pkg::OFS_EDGE, 8'h00);
		wr(irqg_pkg::OFS_SHARED, 8'h82);
		edge_try(8'hFD, 8'hFF, 3'h7, 8'h00);
		edge_try(8'hFD, 8'hFD, 3'h7, 8'h02);
		edge_try(8'h7D, 8'hFD, 3'h7, 8'h00);
		edge_try(8'h7D, 8'hFD, 3'h3, 8'h80);
		edge_try(8'h7D, 8'hFD, 3'h1, 8'h00);
		edge_try(8'h7D, 8'hED, 3'h1, 8'h00);
		$display("shared select done");
	endtask

	task automatic t_prio;
		logic [1:0] lv;
		wr(irqg_pkg::OFS_STATUS, 8'hFF);
		portc_req_i <= 4'h1;
		wr(irqg_pkg::OFS_CTRL, 8'h80);
		for (int c = 0; c < 4; c++)
		begin
			lv = 2'(c);
			wr(irqg_pkg::OFS_G3_HI, {7'h00, lv[1]});
			wr(irqg_pkg::OFS_G3_LO, {7'h00, lv[0]});
			cpu_chk(lv != 2'h0, lv);
		end
		timer_a_req_i <= 1'b1;
		wr(irqg_pkg::OFS_G3_HI, 8'h80);
		wr(irqg_pkg::OFS_G3_LO, 8'h01);
		cpu_chk(1'b1, 2'h2);
		multichannel_timer_req_i <= 1'b1;
		wr(irqg_pkg::OFS_G3_HI, 8'hC0);
		wr(irqg_pkg::OFS_G3_LO, 8'h41);
		cpu_chk(1'b1, 2'h3);
		wr(irqg_pkg::OFS_CTRL, 8'h00);
		cpu_chk(1'b0, 2'h0);
		$display("priority done");
	endtask

	task automatic t_irq;
		portc_req_i <= 4'h0;
		timer_a_req_i <= 1'b0;
		multichannel_timer_req_i <= 1'b0;
		wr(irqg_pkg::OFS_MASK, 8'h01);
		edge_try(8'h7C, 8'hED, 3'h1, 8'h01);
		settle;
		check("irq", {7'h00, irq_o}, 8'h01);
		rd_chk(irqg_pkg::OFS_STATUS, 8'h01, "status");
		wr(irqg_pkg::OFS_G2_HI, 8'h01);
		wr(irqg_pkg::OFS_CTRL, 8'h80);
		cpu_chk(1'b1, 2'h2);
		wr(irqg_pkg::OFS_STATUS, 8'h01);
		settle;
		check("irq", {7'h00, irq_o}, 8'h00);
		wr(irqg_pkg::OFS_MASK, 8'h00);
		edge_try(8'h7D, 8'hED, 3'h1, 8'h00);
		edge_try(8'h7C, 8'hED, 3'h1, 8'h01);
		settle;
		check("irq", {7'h00, irq_o}, 8'h00);
		$display("interrupt done");
	endtask

	task automatic t_regs;
		wr(irqg_pkg::OFS_G2_HI, 8'hA5);
		rd_chk(irqg_pkg::OFS_G2_HI, 8'hA5, "g2_hi");
		wr(irqg_pkg::OFS_G2_LO, 8'h5A);
		rd_chk(irqg_pkg::OFS_G2_LO, 8'h5A, "g2_lo");
		wr(irqg_pkg::OFS_G3_HI, 8'hCF);
		rd_chk(irqg_pkg::OFS_G3_HI, 8'hCF, "g3_hi");
		wr(irqg_pkg::OFS_G3_LO, 8'hCF);
		rd_chk(irqg_pkg::OFS_G3_LO, 8'hCF, "g3_lo");
		wr(irqg_pkg::OFS_EDGE, 8'h3C);
		rd_chk(irqg_pkg::OFS_EDGE, 8'h3C, "edge");
		$display("registers done");
	endtask

	// Reset again with live settings and a pending request
	task automatic t_rerun;
		@(posedge clock_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		cpu_chk(1'b0, 2'h0);
		check("irq", {7'h00, irq_o}, 8'h00);
		rd_chk(irqg_pkg::OFS_G2_HI, 8'h00, "g2_hi");
		rd_chk(irqg_pkg::OFS_G3_LO, 8'h00, "g3_lo");
		rd_chk(irqg_pkg::OFS_EDGE, 8'h00, "edge");
		rd_chk(irqg_pkg::OFS_STATUS, 8'h00, "status");
		$display("mid-run reset done");
	endtask

	// Every alternate source on rising edges, then pin A2 falling
	task automatic t_alt;
		edge_try(8'hFF, 8'hFF, 3'h7, 8'h00);
		wr(irqg_pkg::OFS_EDGE, 8'hFF);
		wr(irqg_pkg::OFS_SHARED, 8'hFE);
		edge_try(8'hFF, 8'hE1, 3'h0, 8'h00);
		edge_try(8'hFF, 8'hFF, 3'h7, 8'hFE);
		edge_try(8'h00, 8'hFF, 3'h7, 8'h00);
		edge_try(8'hFF, 8'hFF, 3'h7, 8'h01);
		wr(irqg_pkg::OFS_SHARED, 8'h00);
		wr(irqg_pkg::OFS_EDGE, 8'h00);
		edge_try(8'hFB, 8'hFF, 3'h7, 8'h04);
		$display("alternate sources done");
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		#200000;
		bad_count++;
		tally_and_finish;
	end

	initial
	begin
		repeat (6) @(posedge clock_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		t_reset;
		t_edge;
		t_shared;
		t_prio;
		t_irq;
		t_regs;
		t_rerun;
		t_alt;
		tally_and_finish;
	end
endmodule // irqg_top_test
`default_nettype wire
